// File: logic/ffmd_consts.svh
// Summary of operation
// - axis_or_combine 0 ANDs enabled axis conditions (freefall), 1 ORs them (motion)
// - motion axis condition: axis magnitude strictly above threshold_level
// - freefall low condition: every enabled axis magnitude at or below threshold_level
// - axis enable bits include axes; disabled axis reads zero motion and sign flags
// - event_active_flag sets when selected combination is true, after debounce
// - latch off: source flags follow real-time event status
// - latch on: source flags freeze when event_active_flag sets until source read
// - latch on: reading source clears event_active_flag and all source flags
// - sign flag 0 for positive, 1 for negative triggering acceleration
// - threshold_level is 7-bit unsigned, 0 to 127 counts, 0.063 g each
// - detection reaches 8 g; low-noise bit limits reachable threshold to 4 g
// - counter_reset_style 1 clears debounce counter on any non-matching sample
// - counter_reset_style 0 decrements counter on non-matching samples down to zero
// - event flag sets when debounce counter reaches debounce_length
// - debounce counter saturates at debounce_length
// - one debounce step is one output sample period
// - event_active_flag is offered to the interrupt logic
// - after reset configuration, flags, threshold, style and length are zero
// - latch off: reading source does not reset event_active_flag
// - latch off with style 1: event_active_flag drops once condition disappears
// - latch on: after source read a new event needs a fresh full debounce
// - detector disabled when all three axis enables are zero
`ifndef FFMD_CONSTS_SVH
`define FFMD_CONSTS_SVH

// register word indices, byte address is four times the index
`define FFMD_IDX_CONFIG 6'h15
`define FFMD_IDX_SOURCE 6'h16
`define FFMD_IDX_THRESH 6'h17
`define FFMD_IDX_DEBLEN 6'h18

// configuration fields
`define FFMD_CFG_LATCH 7
`define FFMD_CFG_ORCOMB 6
`define FFMD_CFG_ZON 5
`define FFMD_CFG_YON 4
`define FFMD_CFG_XON 3

// source fields
`define FFMD_SRC_EA 7
`define FFMD_SRC_ZHE 5
`define FFMD_SRC_ZSG 4
`define FFMD_SRC_YHE 3
`define FFMD_SRC_YSG 2
`define FFMD_SRC_XHE 1
`define FFMD_SRC_XSG 0

// threshold fields
`define FFMD_THS_STYLE 7

// reset values
`define FFMD_RST_CONFIG 5'h00
`define FFMD_RST_THRESH 7'h00
`define FFMD_RST_STYLE 1'b0
`define FFMD_RST_DEBLEN 8'h00
`define FFMD_RST_COUNT 8'h00

// sample scale: 16 sample counts per threshold count, 4 g cap in low noise
`define FFMD_MAG_SHIFT 4
`define FFMD_LN_THS_MAX 7'h40

`endif

// File: logic/ffmd_pkg.sv
package ffmd_pkg;

    typedef enum logic [1:0] {
        FFMD_FREEFALL = 2'b01,
        FFMD_MOTION = 2'b10
    } ffmd_mode_t;

    typedef logic signed [11:0] ffmd_sample_t;

endpackage

// File: logic/ffmd_detector.sv
`timescale 1ns/1ps
`include "ffmd_consts.svh"

module ffmd_detector
    import ffmd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // acceleration samples at the output data rate
    input wire logic sample_valid_i,
    input wire ffmd_sample_t x_i,
    input wire ffmd_sample_t y_i,
    input wire ffmd_sample_t z_i,
    input wire logic low_noise_i,
    // event to interrupt logic
    output logic event_active_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] mag_of(input ffmd_sample_t s);
        logic [11:0] a;
        a = s[11] ? 12'(-s) : 12'(s);
        return 8'(a >> `FFMD_MAG_SHIFT);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
        return (a[7:2] == idx);
    endfunction

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic req, wr_take, rd_take, src_rd;

    // ----------------------------------------
    // registers and detector state
    // ----------------------------------------
    logic [4:0] cfg_q, cfg_d;
    logic [6:0] ths_q, ths_d;
    logic style_q, style_d;
    logic [7:0] len_q, len_d;
    logic [7:0] cnt_q, cnt_d;
    logic ea_q, ea_d;
    logic [5:0] flg_q, flg_d;

    logic latch_on, or_comb, zon, yon, xon, any_on;
    ffmd_mode_t mode;
    logic [6:0] ths_eff;
    logic [2:0] en, hi, lo, neg;
    logic cond, frozen;
    logic [7:0] src_byte;

    assign req = cyc_i && stb_i;
    // commit on the edge where the master samples ack
    assign wr_take = req && ack_q && we_i && sel_i[0];
    assign rd_take = req && ack_q && !we_i;
    assign src_rd = rd_take && hit(adr_i, `FFMD_IDX_SOURCE);

    assign latch_on = cfg_q[`FFMD_CFG_LATCH - 3];
    assign or_comb = cfg_q[`FFMD_CFG_ORCOMB - 3];
    assign zon = cfg_q[`FFMD_CFG_ZON - 3];
    assign yon = cfg_q[`FFMD_CFG_YON - 3];
    assign xon = cfg_q[`FFMD_CFG_XON - 3];
    assign en = {zon, yon, xon};
    assign any_on = |en;
    assign mode = or_comb ? FFMD_MOTION : FFMD_FREEFALL;

    // low noise caps the reachable threshold at 4 g
    assign ths_eff = (low_noise_i && ths_q > `FFMD_LN_THS_MAX) ? `FFMD_LN_THS_MAX : ths_q;

    always_comb begin
        hi = 3'h0;
        lo = 3'h0;
        neg = {z_i[11], y_i[11], x_i[11]};
        hi[0] = mag_of(x_i) > {1'b0, ths_eff};
        hi[1] = mag_of(y_i) > {1'b0, ths_eff};
        hi[2] = mag_of(z_i) > {1'b0, ths_eff};
        lo = ~hi;
        case (mode)
            FFMD_MOTION: cond = any_on && |(hi & en);
            FFMD_FREEFALL: cond = any_on && &(lo | ~en);
            default: cond = 1'b0;
        endcase
        if (!any_on) begin
            cond = 1'b0;
        end
    end

    // flags frozen only while a latched event stands
    assign frozen = latch_on && ea_q;

    // masking at the read keeps flags of a disabled axis quiet even while frozen
    always_comb begin
        src_byte = 8'h00;
        src_byte[`FFMD_SRC_EA] = ea_q;
        src_byte[`FFMD_SRC_ZHE] = flg_q[5] & zon;
        src_byte[`FFMD_SRC_ZSG] = flg_q[4] & zon;
        src_byte[`FFMD_SRC_YHE] = flg_q[3] & yon;
        src_byte[`FFMD_SRC_YSG] = flg_q[2] & yon;
        src_byte[`FFMD_SRC_XHE] = flg_q[1] & xon;
        src_byte[`FFMD_SRC_XSG] = flg_q[0] & xon;
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    always_comb begin
        ack_d = req && !ack_q;
        rdat_d = rdat_q;
        if (req && !ack_q && !we_i) begin
            if (hit(adr_i, `FFMD_IDX_CONFIG)) begin
                rdat_d = {24'h000000, cfg_q, 3'h0};
            end else if (hit(adr_i, `FFMD_IDX_SOURCE)) begin
                rdat_d = {24'h000000, src_byte};
            end else if (hit(adr_i, `FFMD_IDX_THRESH)) begin
                rdat_d = {24'h000000, style_q, ths_q};
            end else if (hit(adr_i, `FFMD_IDX_DEBLEN)) begin
                rdat_d = {24'h000000, len_q};
            end else begin
                rdat_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        ths_d = ths_q;
        style_d = style_q;
        len_d = len_q;
        if (wr_take) begin
            if (hit(adr_i, `FFMD_IDX_CONFIG)) begin
                cfg_d = dat_i[7:3];
            end else if (hit(adr_i, `FFMD_IDX_THRESH)) begin
                style_d = dat_i[`FFMD_THS_STYLE];
                ths_d = dat_i[6:0];
            end else if (hit(adr_i, `FFMD_IDX_DEBLEN)) begin
                len_d = dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= `FFMD_RST_CONFIG;
            ths_q <= `FFMD_RST_THRESH;
            style_q <= `FFMD_RST_STYLE;
            len_q <= `FFMD_RST_DEBLEN;
        end else begin
            cfg_q <= cfg_d;
            ths_q <= ths_d;
            style_q <= style_d;
            len_q <= len_d;
        end
    end

    // ----------------------------------------
    // debounce and event flags
    // ----------------------------------------
    // with latch on, a source read and a sample in one cycle: the read clears first, then
    // the sample counts from zero, so a set still wins over the clear
    always_comb begin
        logic [7:0] base;
        logic ea_base;
        logic [5:0] flg_base;
        base = cnt_q;
        ea_base = ea_q;
        flg_base = flg_q;
        if (src_rd && latch_on) begin
            base = `FFMD_RST_COUNT;
            ea_base = 1'b0;
            flg_base = 6'h00;
        end
        cnt_d = base;
        ea_d = ea_base;
        flg_d = flg_base;
        if (sample_valid_i) begin
            if (!any_on) begin
                cnt_d = `FFMD_RST_COUNT;
            end else if (cond) begin
                cnt_d = (base >= len_q) ? len_q : base + 8'h01;
            end else if (style_q) begin
                cnt_d = `FFMD_RST_COUNT;
            end else if (base != 8'h00) begin
                cnt_d = base - 8'h01;
            end
            if (cond && cnt_d == len_q) begin
                ea_d = 1'b1;
            end else if (!latch_on && cnt_d == 8'h00) begin
                ea_d = 1'b0;
            end
            if (!(latch_on && ea_base)) begin
                flg_d = {hi[2] & zon, neg[2] & hi[2] & zon,
                         hi[1] & yon, neg[1] & hi[1] & yon,
                         hi[0] & xon, neg[0] & hi[0] & xon};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= `FFMD_RST_COUNT;
            ea_q <= 1'b0;
            flg_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
            ea_q <= ea_d;
            flg_q <= flg_d;
        end
    end

    // feeds the interrupt enable and routing logic elsewhere
    assign event_active_o = ea_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not one cycle after request");

    a_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> cfg_q == 5'h00 && ths_q == 7'h00 && !style_q && len_q == 8'h00 && !ea_q)
        else $error("state not zero after reset");

    a_disabled_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && en == 3'h0 |=> cnt_q == 8'h00)
        else $error("counter moved while all axes off");

    a_clear_style: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !cond && style_q |=> cnt_q == 8'h00)
        else $error("counter not cleared on miss");

    a_decrement_step: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && any_on && !cond && !style_q && cnt_q != 8'h00 && !(src_rd && latch_on)
        |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("counter did not decrement by one");

    a_count_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && cond && !wr_take |=> cnt_q <= len_q)
        else $error("counter above debounce length");

    a_event_reach: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ea_q) |-> cnt_q == len_q && $past(sample_valid_i))
        else $error("event set before length reached");

    a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        latch_on && ea_q && !src_rd && !wr_take |=> ea_q && $stable(flg_q))
        else $error("latched source changed before read");

    a_latch_read: assert property (@(posedge clk_i) disable iff (rst_i)
        src_rd && latch_on && !sample_valid_i |=> !ea_q && flg_q == 6'h00 && cnt_q == 8'h00)
        else $error("latched read did not clear source");

    a_read_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        src_rd && !latch_on && ea_q && !sample_valid_i |=> ea_q)
        else $error("plain read cleared event");

    a_drop_style: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !latch_on && style_q && !cond |=> !ea_q)
        else $error("event did not drop on miss");

    a_axis_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !frozen && xon |=> flg_q[1] == $past(hi[0]))
        else $error("x motion flag wrong");

    a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !ack_o)
        else $error("ack without request");

    a_read_thresh: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && hit(adr_i, `FFMD_IDX_THRESH) |-> dat_o == {24'h000000, style_q, ths_q})
        else $error("threshold read data wrong");

    a_read_length: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && hit(adr_i, `FFMD_IDX_DEBLEN) |-> dat_o == {24'h000000, len_q})
        else $error("length read data wrong");

    a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_i[7:2] < `FFMD_IDX_CONFIG |-> dat_o == 32'h00000000)
        else $error("unmapped read not zero");

    a_write_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit(adr_i, `FFMD_IDX_CONFIG) |=> cfg_q == $past(dat_i[7:3]))
        else $error("config write lost");

    a_write_ths: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit(adr_i, `FFMD_IDX_THRESH) |=> {style_q, ths_q} == $past(dat_i[7:0]))
        else $error("threshold write lost");

    a_write_len: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit(adr_i, `FFMD_IDX_DEBLEN) |=> len_q == $past(dat_i[7:0]))
        else $error("length write lost");

    a_src_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit(adr_i, `FFMD_IDX_SOURCE) && !sample_valid_i |=> $stable(ea_q) && $stable(flg_q))
        else $error("source changed by write");

    a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !sample_valid_i && !(src_rd && latch_on) |=> $stable(cnt_q))
        else $error("counter moved between samples");

    a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && cond && cnt_q < len_q && !wr_take && !(src_rd && latch_on)
        |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not step up");

    a_motion_any: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && or_comb && xon && mag_of(x_i) > {1'b0, ths_eff} && !wr_take
        |=> cnt_q != 8'h00 || len_q == 8'h00)
        else $error("motion hit not counted");

    a_freefall_miss: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !or_comb && xon && mag_of(x_i) > {1'b0, ths_eff}
        |=> cnt_q == 8'h00 || cnt_q < $past(cnt_q))
        else $error("freefall counted a high axis");

    a_threshold_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && low_noise_i && or_comb && xon && mag_of(x_i) > {1'b0, `FFMD_LN_THS_MAX}
        && !wr_take |=> cnt_q != 8'h00 || len_q == 8'h00)
        else $error("low noise cap not applied");

    a_event_at_len: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && cond && cnt_q >= len_q && !wr_take && !(src_rd && latch_on)
        |=> ea_q)
        else $error("event not set at length");

    a_zero_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && any_on && !cond && !style_q && cnt_q == 8'h00 |=> cnt_q == 8'h00)
        else $error("counter went below zero");

    a_fresh_count: assert property (@(posedge clk_i) disable iff (rst_i)
        src_rd && latch_on && len_q > 8'h01 && !wr_take |=> !ea_q)
        else $error("event without fresh debounce");

    a_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !any_on && !latch_on |=> !ea_q)
        else $error("event while all axes off");

    a_flag_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !xon && !frozen |=> flg_q[1:0] == 2'b00)
        else $error("disabled x axis flagged");

    a_sign_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !frozen && xon |=> flg_q[0] == ($past(x_i[11]) && $past(hi[0])))
        else $error("x sign flag wrong");

    a_y_sign: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !frozen && yon |=> flg_q[2] == ($past(y_i[11]) && $past(hi[1])))
        else $error("y sign flag wrong");

    a_flags_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !latch_on && zon |=> flg_q[5] == $past(hi[2]))
        else $error("z flag not real time");

endmodule

// File: verification/tb_ffmd_detector.sv
`timescale 1ns/1ps
module tb_ffmd_detector import ffmd_pkg::*;;
    // --------
    // signals
    // --------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic low_noise_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    ffmd_sample_t x_i = 12'h000;
    ffmd_sample_t y_i = 12'h000;
    ffmd_sample_t z_i = 12'h000;
    logic [31:0] dat_o;
    logic ack_o;
    logic event_active_o;
    logic [7:0] exp_q[$];
    logic [7:0] mon_e;
    int n_fail = 0;
    int samples_checked = 0;
    integer seed = 32'h3A1044BC;

    ffmd_detector i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .sample_valid_i(sample_valid_i), .x_i(x_i), .y_i(y_i), .z_i(z_i),
        .low_noise_i(low_noise_i), .event_active_o(event_active_o));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // --------
    // helpers
    // --------
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic bad(input string what, input logic [31:0] e, input logic [31:0] s);
        n_fail++;
        $display("unexpected %s expected %h seen %h", what, e, s);
    endtask

    function automatic int rnd();
        return $random(seed);
    endfunction

    // read results are checked here, oldest note first
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            samples_checked++;
            if (exp_q.size() == 0) begin
                bad("read data", 32'h0000_0000, dat_o);
            end else begin
                mon_e = exp_q.pop_front();
                if (dat_o !== {24'h00_0000, mon_e}) begin
                    bad("read data", {24'h00_0000, mon_e}, dat_o);
                end
                if (adr_i == 8'h58 && event_active_o !== mon_e[7]) begin
                    bad("event line", {31'h0, mon_e[7]}, {31'h0, event_active_o});
                end
            end
        end
    end

    // master never assumes a latency, only the bound cuts a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h00_0000, d};
        for (k = 0; k < 16; k++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (k == 16) begin
            bad("ack wait", 32'h0000_0001, 32'h0000_0000);
            wrap_up();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 8'h00);
    endtask

    task automatic cfg(input logic [7:0] c, input logic [7:0] t, input logic [7:0] l);
        wb(1'b1, 8'h54, c);
        wb(1'b1, 8'h5C, t);
        wb(1'b1, 8'h60, l);
    endtask

    task automatic smp(input int x, input int y, input int z);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        x_i <= 12'(x);
        y_i <= 12'(y);
        z_i <= 12'(z);
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
    endtask

    // --------
    // sequence
    // --------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h54, 8'h00);
        rd(8'h58, 8'h00);
        rd(8'h5C, 8'h00);
        rd(8'h60, 8'h00);
        rd(8'h00, 8'h00);
        wb(1'b1, 8'h58, 8'hFF);
        rd(8'h58, 8'h00);
        wb(1'b1, 8'h54, 8'hFF);
        rd(8'h54, 8'hF8);
        $display("test reset and access done");
        // motion, latch off, clear style; y and z off and fed noise
        cfg(8'h48, 8'h85, 8'h02);
        rd(8'h5C, 8'h85);
        smp(95, rnd(), rnd()); rd(8'h58, 8'h00);
        smp(-96, rnd(), rnd()); rd(8'h58, 8'h03);
        smp(-96, rnd(), rnd()); rd(8'h58, 8'h83);
        rd(8'h58, 8'h83);
        smp(0, rnd(), rnd()); rd(8'h58, 8'h00);
        smp(96, rnd(), rnd()); rd(8'h58, 8'h02);
        smp(96, rnd(), rnd()); rd(8'h58, 8'h82);
        smp(0, 0, 0);
        $display("test motion done");
        // freefall, decrement style; saturation shows in the slow fall
        cfg(8'h38, 8'h04, 8'h02);
        repeat (3) smp(79, -79, 79);
        rd(8'h58, 8'h80);
        smp(80, 0, 0); rd(8'h58, 8'h82);
        smp(80, 0, 0); rd(8'h58, 8'h02);
        $display("test freefall done");
        // latched motion
        cfg(8'hC8, 8'h85, 8'h02);
        smp(96, 0, 0);
        smp(96, 0, 0);
        smp(-96, 0, 0);
        rd(8'h58, 8'h82);
        rd(8'h58, 8'h00);
        smp(96, 0, 0);
        smp(-96, 0, 0);
        rd(8'h58, 8'h83);
        $display("test latch done");
        // low noise caps the threshold
        cfg(8'h48, 8'h7F, 8'h01);
        smp(2047, 0, 0); rd(8'h58, 8'h00);
        low_noise_i <= 1'b1;
        smp(2047, 0, 0); rd(8'h58, 8'h82);
        low_noise_i <= 1'b0;
        // no axis enabled
        cfg(8'h40, 8'h80, 8'h00);
        smp(2047, 2047, -2047); rd(8'h58, 8'h00);
        $display("test limits done");
        wrap_up();
    end
endmodule
